// ---- inc/pdr_pkg.sv ----
// constants and types for the palette converter host register port
package pdr_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int DIR_BIT = 7;
    localparam int ENTRY_W = 24;
    localparam logic [3:0] ADDR_WR_INDEX = 4'h0;
    localparam logic [3:0] ADDR_COLOR = 4'h1;
    localparam logic [3:0] ADDR_MASK = 4'h2;
    localparam logic [3:0] ADDR_RD_INDEX = 4'h3;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [7:0] RSVD_READ = 8'h00;
    localparam logic [1:0] COMP_RED = 2'h0;
    localparam logic [1:0] COMP_GREEN = 2'h1;
    localparam logic [1:0] COMP_BLUE = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} pdr_state_t;
endpackage

// ---- sim/pdr_host_model.sv ----
// host side model: drives the access strobe and the shared bus
`timescale 1ns/1ns
module pdr_host_model (
    input wire logic clk,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    output logic select_n,
    output logic [7:0] ad_in
);
    logic host_en;
    logic [7:0] host_val;
    logic [7:0] last_val = 8'h00;
    // a floating bus toggles so a stale value never passes
    assign ad_in = ad_oe ? ad_out : (host_en ? host_val : ~last_val);
    always @(posedge clk) last_val <= ad_in;
    initial begin
        select_n = 1'b1;
        host_en = 1'b1;
        host_val = 8'h00;
    end
    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        @(negedge clk);
        select_n = 1'b0;
        host_val = {4'h0, addr};
        @(negedge clk);
        host_val = data;
        @(negedge clk);
        select_n = 1'b1;
    endtask
    task automatic rd(input logic [3:0] addr, output logic [7:0] data);
        int n;
        @(negedge clk);
        select_n = 1'b0;
        host_val = {4'h8, addr};
        @(negedge clk);
        host_en = 1'b0;
        data = 8'hxx;
        n = 0;
        // sampled at the falling edge, where the registered output has settled
        while (ad_oe !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (ad_oe === 1'b1) data = ad_in;
        @(negedge clk);
        select_n = 1'b1;
        host_en = 1'b1;
    endtask
endmodule

// ---- sim/pdr_top_test.sv ----
// self-checking bench for the palette converter host register port
`timescale 1ns/1ns
module pdr_top_test;
    import pdr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_reset = 1'b0;
    logic select_n;
    logic [7:0] ad_in;
    logic [7:0] ad_out;
    logic ad_oe;
    logic [7:0] pix_index = 8'h00;
    logic [23:0] pix_rgb;
    logic [23:0] pal [256];
    logic [7:0] rv;
    logic [7:0] base;
    int mismatches = 0;
    int n_checks = 0;
    always #4 ref_clk = ~ref_clk;
    pdr_host_model host_u (.clk(ref_clk), .ad_out(ad_out), .ad_oe(ad_oe),
        .select_n(select_n), .ad_in(ad_in));
    pdr_top dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .SOFT_RESET(soft_reset),
        .SELECT_N(select_n), .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE(ad_oe),
        .PIX_INDEX(pix_index), .PIX_RGB(pix_rgb));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [23:0] exp_pix(input logic [7:0] p, input logic [7:0] m);
        return pal[p & m];
    endfunction
    task automatic read_check(input logic [3:0] a, input logic [7:0] exp);
        host_u.rd(a, rv);
        check({16'h0, rv}, {16'h0, exp});
    endtask
    initial begin
        logic [7:0] m;
        logic [23:0] c;
        void'($urandom(32'h77f2));
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        check({23'h0, ad_oe}, 24'h0);
        check({16'h0, ad_out}, 24'h0);
        check(pix_rgb, 24'h0);
        read_check(ADDR_MASK, MASK_RESET);
        m = 8'($urandom);
        host_u.wr(ADDR_MASK, m);
        read_check(ADDR_MASK, m);
        base = 8'($urandom) & 8'hfc;
        // a stray component must not survive an index load
        host_u.wr(ADDR_COLOR, 8'($urandom));
        host_u.wr(ADDR_WR_INDEX, base);
        read_check(ADDR_WR_INDEX, base);
        for (int e = 0; e < 2; e++) begin
            c = 24'($urandom);
            pal[base + 8'(e)] = c;
            host_u.wr(ADDR_COLOR, c[23:16]);
            host_u.wr(ADDR_COLOR, c[15:8]);
            host_u.wr(ADDR_COLOR, c[7:0]);
        end
        read_check(ADDR_WR_INDEX, base + 8'h2);
        host_u.rd(ADDR_COLOR, rv);
        host_u.wr(ADDR_RD_INDEX, base);
        read_check(ADDR_RD_INDEX, base);
        for (int e = 0; e < 6; e++) begin
            c = pal[base + 8'(e / 3)];
            read_check(ADDR_COLOR, c[23 - 8 * (e % 3) -: 8]);
        end
        read_check(ADDR_RD_INDEX, base + 8'h2);
        for (int k = 0; k < 2; k++) begin
            m = (k == 0) ? 8'hff : 8'hfe;
            host_u.wr(ADDR_MASK, m);
            for (int e = 0; e < 2; e++) begin
                @(negedge ref_clk);
                pix_index = base + 8'(e);
                @(negedge ref_clk);
                check(pix_rgb, exp_pix(pix_index, m));
            end
        end
        // reserved writes must not alias onto a real register
        for (int a = 4; a < 8; a++) begin
            host_u.wr(4'(a), 8'($urandom));
            read_check(4'(a), RSVD_READ);
        end
        read_check(ADDR_MASK, 8'hfe);
        read_check(ADDR_WR_INDEX, base + 8'h2);
        @(negedge ref_clk);
        soft_reset = 1'b1;
        @(negedge ref_clk);
        soft_reset = 1'b0;
        read_check(ADDR_MASK, MASK_RESET);
        read_check(ADDR_WR_INDEX, base + 8'h2);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end
endmodule

// ---- verilog/pdr_palette.sv ----
// palette storage: one host write port, host and pixel read ports
`timescale 1ns/1ns
module pdr_palette #(
    parameter int IDX_W = 8,
    parameter int ENTRY_W = 24
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [ENTRY_W-1:0] wr_data,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [ENTRY_W-1:0] rd_data,
    input wire logic [IDX_W-1:0] pix_idx,
    output logic [ENTRY_W-1:0] pix_data
);
    logic [ENTRY_W-1:0] mem [0:(1<<IDX_W)-1];

    // contents are not reset, as the lookup table holds no defined value
    for (genvar i = 0; i < (1 << IDX_W); i++) begin : g_entry
        always_ff @(posedge clk) begin
            if (wr_en && wr_idx == IDX_W'(i)) begin
                mem[i] <= wr_data;
            end
        end
    end

    assign rd_data = mem[rd_idx];
    assign pix_data = mem[pix_idx];
endmodule

// ---- verilog/pdr_top.sv ----
// host register port of the palette converter, with masked pixel lookup
`timescale 1ns/1ns
module pdr_top (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic SOFT_RESET,
    input wire logic SELECT_N,
    input wire logic [pdr_pkg::DATA_W-1:0] AD_IN,
    output logic [pdr_pkg::DATA_W-1:0] AD_OUT,
    output logic AD_OE,
    input wire logic [pdr_pkg::DATA_W-1:0] PIX_INDEX,
    output logic [pdr_pkg::ENTRY_W-1:0] PIX_RGB
);
    import pdr_pkg::*;

    logic sel_q_reg;
    pdr_state_t state_reg;
    pdr_state_t state_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] mask_reg;
    logic [DATA_W-1:0] mask_next;
    logic [DATA_W-1:0] wr_index_reg;
    logic [DATA_W-1:0] wr_index_next;
    logic [DATA_W-1:0] rd_index_reg;
    logic [DATA_W-1:0] rd_index_next;
    logic [1:0] wr_comp_reg;
    logic [1:0] wr_comp_next;
    logic [1:0] rd_comp_reg;
    logic [1:0] rd_comp_next;
    logic [DATA_W-1:0] red_reg;
    logic [DATA_W-1:0] green_reg;
    logic [DATA_W-1:0] ad_out_reg;
    logic ad_oe_reg;
    logic [ENTRY_W-1:0] pix_rgb_reg;
    logic [ENTRY_W-1:0] pal_rd_data;
    logic [ENTRY_W-1:0] pal_pix_data;

    wire strobe_fall = sel_q_reg & ~SELECT_N;
    wire strobe_rise = ~sel_q_reg & SELECT_N;
    wire commit_wr = strobe_rise && state_reg == ST_WRITE;
    wire commit_rd = strobe_rise && state_reg == ST_READ;
    wire any_reset = ~RST_N | SOFT_RESET;
    // anything outside 0..3 is reserved
    wire is_rsvd = addr_reg[3:2] != 2'h0;
    wire sel_wr_index = addr_reg == ADDR_WR_INDEX;
    wire sel_color = addr_reg == ADDR_COLOR;
    wire sel_mask = addr_reg == ADDR_MASK;
    wire sel_rd_index = addr_reg == ADDR_RD_INDEX;
    wire wr_blue = commit_wr && sel_color && wr_comp_reg == COMP_BLUE;
    wire rd_blue = commit_rd && sel_color && rd_comp_reg == COMP_BLUE;
    wire pal_we = wr_blue;
    wire [ENTRY_W-1:0] pal_wr_data = {red_reg, green_reg, wdata_reg};
    wire [DATA_W-1:0] color_value = (rd_comp_reg == COMP_RED) ? pal_rd_data[23:16] :
                                    (rd_comp_reg == COMP_GREEN) ? pal_rd_data[15:8] :
                                    pal_rd_data[7:0];
    // only four registers answer; everything else reads as zero
    wire [DATA_W-1:0] read_value = sel_wr_index ? wr_index_reg :
                                   sel_color ? color_value :
                                   sel_mask ? mask_reg :
                                   sel_rd_index ? rd_index_reg : RSVD_READ;
    wire drive_now = state_reg == ST_READ && !SELECT_N;
    wire [DATA_W-1:0] pix_idx_masked = PIX_INDEX & mask_reg;

    // direction from bit 7 at the falling strobe edge
    assign state_next = strobe_fall ? (AD_IN[DIR_BIT] ? ST_READ : ST_WRITE) :
                        strobe_rise ? ST_IDLE : state_reg;
    assign mask_next = (commit_wr && sel_mask) ? wdata_reg : mask_reg;
    assign wr_index_next = (commit_wr && sel_wr_index) ? wdata_reg :
                           wr_blue ? wr_index_reg + 8'h01 : wr_index_reg;
    assign rd_index_next = (commit_wr && sel_rd_index) ? wdata_reg :
                           rd_blue ? rd_index_reg + 8'h01 : rd_index_reg;
    // loading an index restarts the red, green, blue sequence
    assign wr_comp_next = (commit_wr && sel_wr_index) ? COMP_RED :
                          (commit_wr && sel_color) ?
                          (wr_blue ? COMP_RED : wr_comp_reg + 2'h1) : wr_comp_reg;
    assign rd_comp_next = (commit_wr && sel_rd_index) ? COMP_RED :
                          (commit_rd && sel_color) ?
                          (rd_blue ? COMP_RED : rd_comp_reg + 2'h1) : rd_comp_reg;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sel_q_reg <= 1'b1;
            state_reg <= ST_IDLE;
            ad_out_reg <= 8'h00;
            ad_oe_reg <= 1'b0;
            pix_rgb_reg <= 24'h000000;
        end else begin
            sel_q_reg <= SELECT_N;
            state_reg <= state_next;
            ad_out_reg <= drive_now ? read_value : 8'h00;
            ad_oe_reg <= drive_now;
            pix_rgb_reg <= pal_pix_data;
        end
    end

    // resettable fields: power-on and soft reset alike
    always_ff @(posedge REF_CLK) begin
        if (any_reset) begin
            mask_reg <= MASK_RESET;
            wr_comp_reg <= COMP_RED;
            rd_comp_reg <= COMP_RED;
        end else begin
            mask_reg <= mask_next;
            wr_comp_reg <= wr_comp_next;
            rd_comp_reg <= rd_comp_next;
        end
    end

    // fields marked not reset keep their value through either reset
    always_ff @(posedge REF_CLK) begin
        wr_index_reg <= wr_index_next;
        rd_index_reg <= rd_index_next;
        if (strobe_fall) begin
            addr_reg <= AD_IN[ADDR_W-1:0];
        end
        // last value seen while low; zero hold time makes the rise cycle unsafe
        if (state_reg == ST_WRITE && !SELECT_N) begin
            wdata_reg <= AD_IN;
        end
        if (commit_wr && sel_color && wr_comp_reg == COMP_RED) begin
            red_reg <= wdata_reg;
        end
        if (commit_wr && sel_color && wr_comp_reg == COMP_GREEN) begin
            green_reg <= wdata_reg;
        end
    end

    pdr_palette #(
        .IDX_W(DATA_W),
        .ENTRY_W(ENTRY_W)
    ) u_palette (
        .clk(REF_CLK),
        .wr_en(pal_we),
        .wr_idx(wr_index_reg),
        .wr_data(pal_wr_data),
        .rd_idx(rd_index_reg),
        .rd_data(pal_rd_data),
        .pix_idx(pix_idx_masked),
        .pix_data(pal_pix_data)
    );

    assign AD_OUT = ad_out_reg;
    assign AD_OE = ad_oe_reg;
    assign PIX_RGB = pix_rgb_reg;

    property p_mask_por;
        @(posedge REF_CLK) disable iff (!RST_N)
        $past(!RST_N) |-> mask_reg == MASK_RESET;
    endproperty
    a_mask_por: assert property (p_mask_por) else $error("mask not ones after reset");

    property p_mask_soft;
        @(posedge REF_CLK) disable iff (!RST_N)
        SOFT_RESET |=> mask_reg == MASK_RESET && wr_comp_reg == COMP_RED;
    endproperty
    a_mask_soft: assert property (p_mask_soft) else $error("soft reset missed fields");

    property p_addr_latch;
        @(posedge REF_CLK) disable iff (!RST_N)
        strobe_fall |=> addr_reg == $past(AD_IN[3:0]) && state_reg == ($past(AD_IN[7]) ?
            ST_READ : ST_WRITE);
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address or direction lost");

    property p_mask_write;
        @(posedge REF_CLK) disable iff (!RST_N || SOFT_RESET)
        commit_wr && sel_mask |=> mask_reg == $past(wdata_reg);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write not taken");

    property p_wr_inc;
        @(posedge REF_CLK) disable iff (!RST_N)
        pal_we |=> wr_index_reg == 8'($past(wr_index_reg) + 8'h01) && wr_comp_reg == COMP_RED;
    endproperty
    a_wr_inc: assert property (p_wr_inc) else $error("write index not advanced");

    property p_rd_inc;
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_blue |=> rd_index_reg == 8'($past(rd_index_reg) + 8'h01);
    endproperty
    a_rd_inc: assert property (p_rd_inc) else $error("read index not advanced");

    property p_rsvd_write;
        @(posedge REF_CLK) disable iff (!RST_N || SOFT_RESET)
        commit_wr && is_rsvd |=> $stable(mask_reg) && $stable(wr_index_reg) &&
            $stable(rd_index_reg);
    endproperty
    a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write changed state");

    property p_rsvd_read;
        @(posedge REF_CLK) disable iff (!RST_N)
        drive_now && is_rsvd |=> AD_OE && AD_OUT == RSVD_READ;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read not zero");

    property p_read_drive;
        @(posedge REF_CLK) disable iff (!RST_N)
        strobe_fall && AD_IN[7] ##1 !SELECT_N |=> AD_OE ##1 (AD_OE || SELECT_N);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven");

    property p_write_quiet;
        @(posedge REF_CLK) disable iff (!RST_N)
        state_reg == ST_WRITE |=> !AD_OE;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("bus driven in write");

    property p_bus_release;
        @(posedge REF_CLK) disable iff (!RST_N)
        !drive_now |=> !AD_OE && AD_OUT == '0;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus not released");

    property p_wr_restart;
        @(posedge REF_CLK) disable iff (!RST_N)
        commit_wr && sel_wr_index |=> wr_comp_reg == COMP_RED;
    endproperty
    a_wr_restart: assert property (p_wr_restart) else $error("write sequence not restarted");

    property p_rd_restart;
        @(posedge REF_CLK) disable iff (!RST_N)
        commit_wr && sel_rd_index |=> rd_comp_reg == COMP_RED;
    endproperty
    a_rd_restart: assert property (p_rd_restart) else $error("read sequence not restarted");
endmodule
